// file: src/reset_combiner_regs.vh
// Register map, field positions and reset values of the reset combiner
`ifndef RESET_COMBINER_REGS_VH
`define RESET_COMBINER_REGS_VH

`define ADDR_CAUSE_STATUS 4'h0
`define ADDR_OSC_CONTROL 4'h4
`define ADDR_IRQ_STATUS 4'h8
`define ADDR_IRQ_ENABLE 4'hc
`define ADDR_IRQ_CLEAR 4'h0

`define BIT_TRAP 15
`define BIT_ILLEGAL 14
`define BIT_FLASH_VREG 11
`define BIT_MISMATCH 9
`define BIT_MAIN_VREG 8
`define BIT_PIN 7
`define BIT_SOFT 6
`define BIT_WDT_EN 5
`define BIT_WDT_TO 4
`define BIT_SLEEP 3
`define BIT_IDLE 2
`define BIT_BROWNOUT 1
`define BIT_POWERON 0

`define CAUSE_WRITE_MASK 16'hcbff
`define CAUSE_POR_VALUE 16'h0003
`define NEXT_OSC_SELECT_LSB 8
`define NEXT_OSC_SELECT_MSB 10
`define OSC_WRITE_MASK 16'h0000
`define NUM_SOURCES 8

`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

// file: src/reset_source_combiner_status.v
// Reset source combiner with cause status and AXI4-Lite registers
// Functional notes
// [RULE1] System reset is high whenever any reset source input is active; the code follows two cycles late, except for raw power-on.
// [RULE2] Every reset kind sets its own cause flag in the status register.
// [RULE3] Power-on clears all status bits except bits 1:0, which it sets.
// [RULE4] Software may set or clear flags; writes never cause a reset.
// [RULE5] Every reset copies default oscillator field into bits 10:8.
// [RULE6] Bit 15 flags a trap-conflict reset.
// [RULE7] Bit 14 flags illegal opcode, address mode or uninitialised pointer.
// [RULE8] Bit 9 flags a configuration-mismatch reset.
// [RULE9] Bit 7 flags a master-clear pin reset.
// [RULE10] Bit 6 flags execution of the reset instruction.
// [RULE11] Bit 4 flags a watchdog time-out.
// [RULE12] Bit 1 flags brown-out, bit 0 power-on; both reset to one.
// [RULE13] Bit 5 enables watchdog; an unprogrammed fuse forces it enabled.
// [RULE14] Bit 3 records sleep, bit 2 records idle.
// [RULE15] Bits 11 and 8 keep flash and main regulators active in sleep.
// [RULE16] Software should clear flags after reading them.
// [RULE17] Non-power-on resets keep earlier flags and add their own.
`include "reset_combiner_regs.vh"

module reset_source_combiner_status (
	input wire aclk,
	input wire aresetn,
	input wire power_on_rst,
	input wire brown_out_rst,
	input wire master_clear_pin_n,
	input wire soft_reset_req,
	input wire watchdog_timeout,
	input wire config_mismatch,
	input wire trap_conflict,
	input wire illegal_op,
	input wire sleep_entered,
	input wire idle_entered,
	input wire watchdog_fuse_enable,
	input wire [2:0] default_osc_fuse,
	input wire [3:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [3:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	output wire master_system_reset,
	output wire watchdog_enable,
	output wire flash_regulator_sleep_active,
	output wire main_regulator_sleep_active,
	output wire [2:0] next_osc_select,
	output wire irq
);

	// Source order: por, bor, pin, soft, wdt, mismatch, trap, illegal
	wire [`NUM_SOURCES-1:0] src_raw;
	reg [`NUM_SOURCES-1:0] src_meta_reg;
	reg [`NUM_SOURCES-1:0] src_sync_reg;
	reg [`NUM_SOURCES-1:0] src_prev_reg;
	reg [1:0] sleep_meta_reg;
	reg [1:0] sleep_sync_reg;
	reg [15:0] reset_cause_status_reg;
	reg [15:0] cause_next;
	reg [15:0] oscillator_control_reg;
	reg [`NUM_SOURCES-1:0] irq_status_reg;
	reg [`NUM_SOURCES-1:0] irq_enable_reg;
	reg aw_held_reg;
	reg w_held_reg;
	reg [3:0] awaddr_reg;
	reg [31:0] wdata_reg;
	reg [3:0] wstrb_reg;
	wire [`NUM_SOURCES-1:0] src_rise;
	wire wr_fire;
	wire [15:0] wr_mask;
	wire [15:0] wr_bits;
	wire cause_wr;
	wire en_wr;
	wire clr_wr;
	wire wr_ok;
	wire any_src;
	genvar g;

	assign src_raw = {illegal_op, trap_conflict, config_mismatch,
		watchdog_timeout, soft_reset_req, ~master_clear_pin_n,
		brown_out_rst, power_on_rst};

	// Sources are asynchronous; each passes two flops before use
	generate
		for (g = 0; g < `NUM_SOURCES; g = g + 1) begin : g_sync
			always @(posedge aclk) begin
				if (!aresetn) begin
					src_meta_reg[g] <= 1'b0;
					src_sync_reg[g] <= 1'b0;
					src_prev_reg[g] <= 1'b0;
				end else begin
					src_meta_reg[g] <= src_raw[g];
					src_sync_reg[g] <= src_meta_reg[g];
					src_prev_reg[g] <= src_sync_reg[g];
				end
			end
			assign src_rise[g] = src_sync_reg[g] & ~src_prev_reg[g];
		end
	endgenerate

	always @(posedge aclk) begin
		if (!aresetn) begin
			sleep_meta_reg <= 2'b00;
			sleep_sync_reg <= 2'b00;
		end else begin
			sleep_meta_reg <= {sleep_entered, idle_entered};
			sleep_sync_reg <= sleep_meta_reg;
		end
	end

	// Raw power-on also forces the output so it is never lost in sync
	assign any_src = |src_sync_reg;
	assign master_system_reset = any_src | power_on_rst; // [RULE1]

	// Write channel: address and data taken in either order
	assign s_axi_awready = ~aw_held_reg & ~s_axi_bvalid;
	assign s_axi_wready = ~w_held_reg & ~s_axi_bvalid;
	assign wr_fire = aw_held_reg & w_held_reg & ~s_axi_bvalid;
	assign wr_ok = (awaddr_reg == `ADDR_CAUSE_STATUS) ||
		(awaddr_reg == `ADDR_OSC_CONTROL) ||
		(awaddr_reg == `ADDR_IRQ_STATUS) ||
		(awaddr_reg == `ADDR_IRQ_ENABLE);
	assign wr_mask = {{8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};
	assign wr_bits = wdata_reg[15:0];
	assign cause_wr = wr_fire && awaddr_reg == `ADDR_CAUSE_STATUS;
	assign en_wr = wr_fire && awaddr_reg == `ADDR_IRQ_ENABLE;
	// Status at 0x8 is write-one-to-clear; a write there clears the bits written as one
	assign clr_wr = wr_fire && awaddr_reg == `ADDR_IRQ_STATUS;

	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_reg <= 1'b0;
			w_held_reg <= 1'b0;
			awaddr_reg <= 4'h0;
			wdata_reg <= 32'h0000_0000;
			wstrb_reg <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_reg <= 1'b1;
				awaddr_reg <= {s_axi_awaddr[3:2], 2'b00};
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_reg <= 1'b1;
				wdata_reg <= s_axi_wdata;
				wstrb_reg <= s_axi_wstrb;
			end
			if (wr_fire) begin
				aw_held_reg <= 1'b0;
				w_held_reg <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Cause flags; hardware set wins over a software clear
	always @* begin
		cause_next = reset_cause_status_reg;
		if (cause_wr) begin
			// Plain store only, no reset path from here [RULE4]
			cause_next = (cause_next & ~(wr_mask & `CAUSE_WRITE_MASK)) |
				(wr_bits & wr_mask & `CAUSE_WRITE_MASK);
		end
		// Earlier flags stay; new ones OR in [RULE17] [RULE2]
		if (src_sync_reg[1]) cause_next[`BIT_BROWNOUT] = 1'b1; // [RULE12]
		if (src_sync_reg[2]) cause_next[`BIT_PIN] = 1'b1; // [RULE9]
		if (src_sync_reg[3]) cause_next[`BIT_SOFT] = 1'b1; // [RULE10]
		if (src_sync_reg[4]) cause_next[`BIT_WDT_TO] = 1'b1; // [RULE11]
		if (src_sync_reg[5]) cause_next[`BIT_MISMATCH] = 1'b1; // [RULE8]
		if (src_sync_reg[6]) cause_next[`BIT_TRAP] = 1'b1; // [RULE6]
		if (src_sync_reg[7]) cause_next[`BIT_ILLEGAL] = 1'b1; // [RULE7]
		if (sleep_sync_reg[1]) cause_next[`BIT_SLEEP] = 1'b1; // [RULE14]
		if (sleep_sync_reg[0]) cause_next[`BIT_IDLE] = 1'b1; // [RULE14]
		if (src_sync_reg[0]) cause_next = `CAUSE_POR_VALUE; // [RULE3]
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			reset_cause_status_reg <= `CAUSE_POR_VALUE; // [RULE12]
		end else begin
			reset_cause_status_reg <= cause_next;
		end
	end

	// Oscillator field reloads while any reset is active [RULE5]
	always @(posedge aclk) begin
		if (!aresetn) begin
			oscillator_control_reg <= 16'h0000;
		end else if (any_src) begin
			oscillator_control_reg <= {5'h00, default_osc_fuse, 8'h00};
		end
	end

	assign next_osc_select =
		oscillator_control_reg[`NEXT_OSC_SELECT_MSB:`NEXT_OSC_SELECT_LSB];
	assign watchdog_enable = watchdog_fuse_enable |
		reset_cause_status_reg[`BIT_WDT_EN]; // [RULE13]
	assign flash_regulator_sleep_active =
		reset_cause_status_reg[`BIT_FLASH_VREG]; // [RULE15]
	assign main_regulator_sleep_active =
		reset_cause_status_reg[`BIT_MAIN_VREG]; // [RULE15]

	// Interrupt status: one sticky bit per source rising edge
	always @(posedge aclk) begin
		if (!aresetn) begin
			irq_status_reg <= {`NUM_SOURCES{1'b0}};
			irq_enable_reg <= {`NUM_SOURCES{1'b0}};
		end else begin
			irq_status_reg <= (irq_status_reg &
				~(clr_wr && wstrb_reg[0] ? wdata_reg[7:0] : 8'h00))
				| src_rise;
			if (en_wr && wstrb_reg[0]) begin
				irq_enable_reg <= wdata_reg[7:0];
			end
		end
	end

	assign irq = |(irq_status_reg & irq_enable_reg);

	// Read channel, one outstanding read
	assign s_axi_arready = ~s_axi_rvalid;

	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= `RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= `RESP_OKAY;
			case ({s_axi_araddr[3:2], 2'b00})
			`ADDR_CAUSE_STATUS: begin
				s_axi_rdata <= {16'h0000, reset_cause_status_reg};
			end
			`ADDR_OSC_CONTROL: begin
				s_axi_rdata <= {16'h0000, oscillator_control_reg};
			end
			`ADDR_IRQ_STATUS: begin
				s_axi_rdata <= {24'h000000, irq_status_reg};
			end
			`ADDR_IRQ_ENABLE: begin
				s_axi_rdata <= {24'h000000, irq_enable_reg};
			end
			default: begin
				s_axi_rdata <= 32'h0000_0000;
				s_axi_rresp <= `RESP_SLVERR;
			end
			endcase
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

endmodule

// file: tb/reset_combiner_monitor.sv
// Port assertions for the reset combiner
module reset_combiner_monitor (
	input wire aclk,
	input wire aresetn,
	input wire power_on_rst,
	input wire brown_out_rst,
	input wire master_clear_pin_n,
	input wire soft_reset_req,
	input wire watchdog_timeout,
	input wire config_mismatch,
	input wire trap_conflict,
	input wire illegal_op,
	input wire watchdog_fuse_enable,
	input wire [2:0] default_osc_fuse,
	input wire s_axi_wvalid,
	input wire master_system_reset,
	input wire watchdog_enable,
	input wire flash_regulator_sleep_active,
	input wire main_regulator_sleep_active,
	input wire [2:0] next_osc_select
);
	wire any_src = power_on_rst | brown_out_rst | ~master_clear_pin_n |
		soft_reset_req | watchdog_timeout | config_mismatch |
		trap_conflict | illegal_op;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// Raw power-on bypasses the synchroniser
	a_por_direct: assert property (power_on_rst |-> master_system_reset)
		else $error("power-on did not reach system reset");
	a_any_source: assert property (any_src [*3] |-> master_system_reset)
		else $error("held source did not assert system reset");
	a_no_source: assert property (!any_src [*3] |-> !master_system_reset)
		else $error("system reset without any source");
	// Two-flop synchroniser latency
	a_sync_lag: assert property (!any_src [*3] ##1 (any_src && !power_on_rst)
		|-> !master_system_reset)
		else $error("system reset ahead of synchroniser");
	a_osc_load: assert property (any_src [*4]
		|-> next_osc_select == default_osc_fuse)
		else $error("oscillator select not loaded in reset");
	a_osc_hold: assert property (!any_src [*5] |-> $stable(next_osc_select))
		else $error("oscillator select moved outside reset");
	a_reg_hold: assert property ((!s_axi_wvalid && !any_src) [*4]
		|-> $stable({flash_regulator_sleep_active,
		main_regulator_sleep_active}))
		else $error("regulator bits moved without a write");
	a_wdt_fuse: assert property (watchdog_fuse_enable |-> watchdog_enable)
		else $error("fuse did not force watchdog enable");
endmodule

bind reset_source_combiner_status reset_combiner_monitor u_mon (.*);

// file: tb/reset_source_model.sv
// Behavioural reset sources, one selected by kind while fire is high
module reset_source_model (
	input wire aclk,
	input wire [3:0] kind,
	input wire fire,
	output reg power_on_rst = 1'b1,
	output reg brown_out_rst = 1'b0,
	output reg master_clear_pin_n = 1'b1,
	output reg soft_reset_req = 1'b0,
	output reg watchdog_timeout = 1'b0,
	output reg config_mismatch = 1'b0,
	output reg trap_conflict = 1'b0,
	output reg illegal_op = 1'b0,
	output reg sleep_entered = 1'b0,
	output reg idle_entered = 1'b0
);
	timeunit 1ns;
	timeprecision 1ns;
	wire [9:0] on = fire ? (10'h001 << kind) : 10'h000;
	// Sources move just after an edge, as real source logic would
	always @(posedge aclk) begin
		power_on_rst <= on[0];
		brown_out_rst <= on[1];
		master_clear_pin_n <= ~on[2]; // Pin is active low
		soft_reset_req <= on[3];
		watchdog_timeout <= on[4];
		config_mismatch <= on[5];
		trap_conflict <= on[6];
		illegal_op <= on[7];
		sleep_entered <= on[8];
		idle_entered <= on[9];
	end
endmodule

// file: tb/reset_source_combiner_status_tb.sv
// Self-checking bench for the reset combiner
module reset_source_combiner_status_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic aclk = 1'b0, aresetn = 1'b0, fire = 1'b1, watchdog_fuse_enable = 1'b0;
	logic [3:0] kind = 4'h0, s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic [2:0] default_osc_fuse = 3'h2;
	logic [31:0] s_axi_wdata = 32'h0, v;
	logic [1:0] resp_b = 2'b11, resp_r = 2'b11;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	wire power_on_rst, brown_out_rst, master_clear_pin_n, soft_reset_req;
	wire watchdog_timeout, config_mismatch, trap_conflict, illegal_op;
	wire sleep_entered, idle_entered, s_axi_awready, s_axi_wready;
	wire s_axi_bvalid, s_axi_arready, s_axi_rvalid, master_system_reset;
	wire watchdog_enable, flash_regulator_sleep_active, irq;
	wire main_regulator_sleep_active;
	wire [1:0] s_axi_bresp, s_axi_rresp;
	wire [31:0] s_axi_rdata;
	wire [2:0] next_osc_select;
	int err_count = 0, samples_checked = 0, cyc = 0;
	int pos [10] = '{0, 1, 7, 6, 4, 9, 15, 14, 3, 2};
	reset_source_model u_src (.*);
	reset_source_combiner_status u_dut (.*);
	initial forever #5 aclk = ~aclk;
	task stop_test;
		$display("checked %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	// Hang guard; the whole run needs well under a thousand cycles
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			err_count++;
			stop_test;
		end
	end
	task chk(input [31:0] got, input [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
			err_count++;
		end
	endtask
	// Handshakes judged on settled values before the edge that takes them
	task wr(input [3:0] a, input [15:0] d);
		bit done, aw_hs, w_hs, b_hs;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= {16'h0000, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		done = 0;
		while (!done) begin
			@(negedge aclk);
			aw_hs = s_axi_awvalid && s_axi_awready;
			w_hs = s_axi_wvalid && s_axi_wready;
			b_hs = s_axi_bvalid && s_axi_bready;
			if (b_hs) resp_b = s_axi_bresp;
			@(posedge aclk);
			if (aw_hs) s_axi_awvalid <= 1'b0;
			if (w_hs) s_axi_wvalid <= 1'b0;
			if (b_hs) begin
				s_axi_bready <= 1'b0;
				done = 1;
			end
		end
	endtask
	task rd(input [3:0] a);
		bit done, ar_hs, r_hs;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		done = 0;
		while (!done) begin
			@(negedge aclk);
			ar_hs = s_axi_arvalid && s_axi_arready;
			r_hs = s_axi_rvalid && s_axi_rready;
			if (r_hs) begin
				v = s_axi_rdata;
				resp_r = s_axi_rresp;
			end
			@(posedge aclk);
			if (ar_hs) s_axi_arvalid <= 1'b0;
			if (r_hs) begin
				s_axi_rready <= 1'b0;
				done = 1;
			end
		end
	endtask
	// Hold one source for three cycles, then let the synchroniser drain
	task src(input [3:0] k);
		@(posedge aclk);
		kind <= k;
		fire <= 1'b1;
		repeat (3) @(posedge aclk);
		fire <= 1'b0;
		repeat (5) @(posedge aclk);
	endtask
	task t_causes;
		default_osc_fuse <= 3'h5;
		for (int k = 1; k < 10; k++) begin
			wr(4'h0, 16'h0000);
			src(k[3:0]);
			rd(4'h0);
			chk(v, 32'h1 << pos[k]);
		end
		rd(4'h4);
		chk(v, 32'h0500);
		$display("causes done");
	endtask
	task t_accum;
		wr(4'h0, 16'h0000);
		src(4'h4);
		src(4'h3);
		rd(4'h0);
		chk(v, 32'h0050);
		src(4'h0);
		rd(4'h0);
		chk(v, 32'h0003);
		$display("accumulate done");
	endtask
	task t_soft;
		wr(4'h0, 16'hffff);
		rd(4'h0);
		chk(v, 32'hcbff);
		chk({resp_b, resp_r}, 0);
		chk(master_system_reset, 0);
		chk(watchdog_enable, 1);
		chk({flash_regulator_sleep_active, main_regulator_sleep_active}, 3);
		wr(4'h0, 16'h0000);
		chk({watchdog_enable, flash_regulator_sleep_active}, 0);
		watchdog_fuse_enable <= 1'b1;
		@(posedge aclk);
		@(negedge aclk);
		chk(watchdog_enable, 1);
		watchdog_fuse_enable <= 1'b0;
		$display("software access done");
	endtask
	task t_irq;
		wr(4'hc, 16'h00ff);
		wr(4'h8, 16'h00ff);
		src(4'h4);
		chk(irq, 1);
		wr(4'h8, 16'h0010);
		chk(irq, 0);
		wr(4'hc, 16'h0000);
		src(4'h4);
		chk(irq, 0);
		rd(4'h8);
		chk(v, 32'h0010);
		$display("interrupt done");
	endtask
	initial begin
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		fire <= 1'b0;
		repeat (5) @(posedge aclk);
		rd(4'h0);
		chk(v, 32'h0003);
		rd(4'h4);
		chk(v, 32'h0200);
		t_causes;
		t_accum;
		t_soft;
		t_irq;
		stop_test;
	end
endmodule
